// ### rtl/fspd_top.sv
// Frame statistics and pixel dump readout behind the two-wire serial port.
`timescale 1ns/1ns
`include "fspd_params.svh"

// Operation
// - Minimum pixel in bits 5:0, top zero.
// - Sum 324 pixels, report bits 14:7.
// - Total register never exceeds 159.
// - Statistics recomputed every frame.
// - Dump read returns SOF, valid, value.
// - Any dump write rewinds pointer to one.
// - Each dump read with valid set advances the pointer.
// - SOF set only for pixel one.
// - Valid set only with captured pixel.
// - After pixel 324, wrap to one.
// - Only one pixel captured per frame.
// - Access arms capture; held until the next dump read or write.
// - Pixels numbered column by column, 18x18.
// - Sleep after idle unless forced awake.
module fspd_top
  import fspd_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = `FSPD_SLEEP_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      arst_n,
  input  wire logic      sck,
  input  wire logic      sdio_i,
  output logic           sdio_o,
  output logic           sdio_oe,
  input  wire fspd_pix_t pix,
  input  wire logic      motion,
  input  wire logic      force_awake,
  output logic           awake
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain.

  fspd_sp_state_t sp_state_q;
  logic [2:0]     bit_cnt_q;
  logic [7:0]     shift_q;
  logic [7:0]     shift_in;
  fspd_req_t      req_q;
  logic           req_tgl_q;
  logic           sdo_q;
  logic           oe_q;
  logic [7:0]     rdata_q;

  assign shift_in = {shift_q[6:0], sdio_i};

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      sp_state_q <= FSPD_SP_ADDR;
      bit_cnt_q  <= 3'h0;
      shift_q    <= 8'h00;
      req_q      <= '0;
      req_tgl_q  <= 1'b0;
    end else begin
      shift_q   <= shift_in;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        case (sp_state_q)
          FSPD_SP_ADDR: begin
            req_q.addr <= shift_in[6:0];
            if (shift_in[`FSPD_WR_FLAG_BIT]) begin
              sp_state_q <= FSPD_SP_WDATA;
            end else begin
              req_q.wr   <= 1'b0;
              req_tgl_q  <= ~req_tgl_q;
              sp_state_q <= FSPD_SP_RDATA;
            end
          end
          FSPD_SP_WDATA: begin
            req_q.wdata <= shift_in;
            req_q.wr    <= 1'b1;
            req_tgl_q   <= ~req_tgl_q;
            sp_state_q  <= FSPD_SP_ADDR;
          end
          FSPD_SP_RDATA: begin
            sp_state_q <= FSPD_SP_ADDR;
          end
          default: begin
            sp_state_q <= FSPD_SP_ADDR;
          end
        endcase
      end
    end
  end

  // The host leaves the clock still between address and data, so the read
  // word has long settled in the core domain before the first falling edge.
  always_ff @(negedge sck or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      oe_q  <= (sp_state_q == FSPD_SP_RDATA);
      sdo_q <= rdata_q[3'(3'h7 - bit_cnt_q)];
    end
  end

  assign sdio_o  = sdo_q;
  assign sdio_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request crossing into the core clock domain.

  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic req_evt;
  logic rd_dump;
  logic wr_dump;
  logic rd_any;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Request fields stay still until the next address byte ends, so they are safe to
  // read once the toggle has passed the synchroniser.
  assign req_evt = req_s2_q ^ req_s3_q;
  assign rd_any  = req_evt && !req_q.wr;
  assign rd_dump = rd_any && (req_q.addr == `FSPD_ADDR_PIXEL_DUMP);
  assign wr_dump = req_evt && req_q.wr && (req_q.addr == `FSPD_ADDR_PIXEL_DUMP);

  ////////////////////////////////////////////////////////////////////////////
  // Frame statistics.

  logic [8:0]  pix_idx_q;
  logic [8:0]  cur_idx;
  logic [5:0]  run_min_q;
  logic [14:0] run_sum_q;
  logic [5:0]  acc_min;
  logic [14:0] acc_sum;
  logic        frame_end;
  logic [5:0]  min_q;
  logic [7:0]  sum_hi_q;

  // Pixels arrive in column order, 18 per column, pixel 1 first.
  assign cur_idx   = pix.first ? `FSPD_FIRST_PIXEL : 9'(pix_idx_q + 9'h001);
  assign frame_end = pix.valid && (cur_idx == `FSPD_PIXELS_PER_FRAME);
  assign acc_min   = (pix.first || (pix.value < run_min_q)) ? pix.value : run_min_q;
  assign acc_sum   = pix.first ? {9'h000, pix.value} : 15'(run_sum_q + {9'h000, pix.value});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_idx_q <= 9'h000;
      run_min_q <= `FSPD_RUN_MIN_RESET;
      run_sum_q <= 15'h0000;
    end else if (pix.valid) begin
      pix_idx_q <= cur_idx;
      run_min_q <= acc_min;
      run_sum_q <= acc_sum;
    end
  end

  // Writes never reach these registers; only the frame end updates them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      min_q    <= `FSPD_MIN_RESET;
      sum_hi_q <= `FSPD_SUM_RESET;
    end else if (frame_end) begin
      min_q    <= acc_min;
      sum_hi_q <= acc_sum[`FSPD_SUM_HI:`FSPD_SUM_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel dump grabber.

  logic [8:0] dump_ptr_q;
  logic       armed_q;
  logic       grab_valid_q;
  logic [5:0] grab_val_q;
  logic       grab_hit;
  logic       dump_sof;

  assign grab_hit = armed_q && pix.valid && (cur_idx == dump_ptr_q);
  assign dump_sof = (dump_ptr_q == `FSPD_FIRST_PIXEL);

  // An access in the same cycle as a hit wins; the grab restarts for pixel one
  // after a write or for the unchanged pointer after a read, which costs at most one frame.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dump_ptr_q   <= `FSPD_FIRST_PIXEL;
      armed_q      <= 1'b0;
      grab_valid_q <= 1'b0;
      grab_val_q   <= 6'h00;
    end else if (wr_dump) begin
      dump_ptr_q   <= `FSPD_FIRST_PIXEL;
      armed_q      <= 1'b1;
      grab_valid_q <= 1'b0;
    end else if (rd_dump) begin
      armed_q      <= 1'b1;
      grab_valid_q <= 1'b0;
      if (grab_valid_q) begin
        dump_ptr_q <= (dump_ptr_q == `FSPD_PIXELS_PER_FRAME) ? `FSPD_FIRST_PIXEL
                                                            : 9'(dump_ptr_q + 9'h001);
      end
    end else if (grab_hit) begin
      armed_q      <= 1'b0;
      grab_valid_q <= 1'b1;
      grab_val_q   <= pix.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_any) begin
      case (req_q.addr)
        `FSPD_ADDR_MIN_PIXEL:   rdata_q <= {2'b00, min_q};
        `FSPD_ADDR_PIXEL_TOTAL: rdata_q <= sum_hi_q;
        `FSPD_ADDR_PIXEL_DUMP:  rdata_q <= {dump_sof, grab_valid_q, grab_val_q};
        default:                rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep control.

  logic [31:0] idle_cnt_q;

  // The counter stops at its limit rather than wrapping, so a long still spell keeps the part asleep.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt_q <= 32'h0000_0000;
      awake      <= 1'b1;
    end else if (force_awake || motion) begin
      idle_cnt_q <= 32'h0000_0000;
      awake      <= 1'b1;
    end else if (idle_cnt_q >= 32'(SLEEP_CYCLES - 1)) begin
      awake      <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_valid_dump_read;
    rd_dump && grab_valid_q && !wr_dump;
  endsequence

  sequence s_quiet;
    !rd_dump && !wr_dump;
  endsequence

  a_sum_bound: assert property (@(posedge clk) disable iff (!arst_n)
    sum_hi_q <= `FSPD_SUM_MAX)
    else $error("Pixel total above bound.");

  a_min_top_zero: assert property (@(posedge clk) disable iff (!arst_n)
    rd_any && (req_q.addr == `FSPD_ADDR_MIN_PIXEL) |=> rdata_q[7:6] == 2'b00 && rdata_q[5:0] == $past(min_q))
    else $error("Minimum pixel read wrong.");

  a_stats_frame: assert property (@(posedge clk) disable iff (!arst_n)
    frame_end |=> min_q == $past(acc_min) && sum_hi_q == $past(acc_sum[`FSPD_SUM_HI:`FSPD_SUM_LO]))
    else $error("Statistics not taken at frame end.");

  a_ro_hold: assert property (@(posedge clk) disable iff (!arst_n)
    req_evt && req_q.wr && !frame_end |=> $stable(min_q) && $stable(sum_hi_q))
    else $error("Statistics changed on write.");

  a_write_rewind: assert property (@(posedge clk) disable iff (!arst_n)
    wr_dump |=> dump_ptr_q == `FSPD_FIRST_PIXEL && armed_q && !grab_valid_q)
    else $error("Dump write did not rewind.");

  a_read_advance: assert property (@(posedge clk) disable iff (!arst_n)
    s_valid_dump_read ##0 (dump_ptr_q != `FSPD_PIXELS_PER_FRAME) |=> dump_ptr_q == 9'($past(dump_ptr_q) + 9'h001))
    else $error("Pointer did not advance.");

  a_ptr_wrap: assert property (@(posedge clk) disable iff (!arst_n)
    s_valid_dump_read ##0 (dump_ptr_q == `FSPD_PIXELS_PER_FRAME) |=> dump_ptr_q == `FSPD_FIRST_PIXEL)
    else $error("Pointer did not wrap.");

  a_dump_flags: assert property (@(posedge clk) disable iff (!arst_n)
    rd_dump |=> rdata_q[7] == ($past(dump_ptr_q) == `FSPD_FIRST_PIXEL) && rdata_q[6] == $past(grab_valid_q))
    else $error("Dump flags wrong.");

  a_grab_hold: assert property (@(posedge clk) disable iff (!arst_n)
    grab_valid_q ##0 s_quiet |=> grab_valid_q && $stable(grab_val_q) && $stable(dump_ptr_q))
    else $error("Grabbed pixel lost.");

  a_one_capture: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(grab_valid_q) |-> $past(armed_q) && !armed_q)
    else $error("Capture without arming.");

  a_forced_awake: assert property (@(posedge clk) disable iff (!arst_n)
    force_awake |=> awake [*2])
    else $error("Forced awake not held.");

  // An access and a capture may meet in one cycle; the access wins, so the
  // capture check leaves those cycles out.
  a_capture_value: assert property (@(posedge clk) disable iff (!arst_n)
    grab_hit ##0 s_quiet |=> grab_valid_q && grab_val_q == $past(pix.value))
    else $error("Captured pixel wrong.");

  a_arm_on_read: assert property (@(posedge clk) disable iff (!arst_n)
    rd_dump |=> armed_q && !grab_valid_q)
    else $error("Dump read did not re-arm.");

  a_invalid_read_hold: assert property (@(posedge clk) disable iff (!arst_n)
    rd_dump && !grab_valid_q |=> $stable(dump_ptr_q))
    else $error("Pointer moved on invalid read.");

  a_sof_clear: assert property (@(posedge clk) disable iff (!arst_n)
    rd_dump && (dump_ptr_q != `FSPD_FIRST_PIXEL) |=> !rdata_q[`FSPD_SOF_BIT])
    else $error("Start flag set away from pixel one.");

  a_dump_value: assert property (@(posedge clk) disable iff (!arst_n)
    rd_dump |=> rdata_q[5:0] == $past(grab_val_q))
    else $error("Dump value wrong.");

  a_total_read: assert property (@(posedge clk) disable iff (!arst_n)
    rd_any && (req_q.addr == `FSPD_ADDR_PIXEL_TOTAL) |=> rdata_q == $past(sum_hi_q))
    else $error("Pixel total read wrong.");

  a_stats_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    !frame_end |=> $stable(min_q) && $stable(sum_hi_q))
    else $error("Statistics changed between frames.");

  a_first_index: assert property (@(posedge clk) disable iff (!arst_n)
    pix.valid && pix.first |=> pix_idx_q == `FSPD_FIRST_PIXEL)
    else $error("First pixel not numbered one.");

  a_sleep_cause: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(awake) |-> !$past(force_awake) && !$past(motion))
    else $error("Slept while held awake.");

endmodule : fspd_top

// ### inc/fspd_params.svh
// Constants for the frame statistics and pixel dump block.
`ifndef FSPD_PARAMS_SVH
`define FSPD_PARAMS_SVH

// Register addresses on the serial port.
`define FSPD_ADDR_MIN_PIXEL   7'h46
`define FSPD_ADDR_PIXEL_TOTAL 7'h47
`define FSPD_ADDR_PIXEL_DUMP  7'h48

// Address byte flag that marks a write.
`define FSPD_WR_FLAG_BIT 7

// Frame geometry.
`define FSPD_ROWS_PER_COLUMN   18
`define FSPD_PIXELS_PER_FRAME  9'd324
`define FSPD_FIRST_PIXEL       9'd1

// Pixel total field and its bound.
`define FSPD_SUM_HI  14
`define FSPD_SUM_LO  7
`define FSPD_SUM_MAX 8'd159

// Dump port field positions.
`define FSPD_SOF_BIT   7
`define FSPD_VALID_BIT 6

// Reset values.
`define FSPD_MIN_RESET 6'h00
`define FSPD_SUM_RESET 8'h00
`define FSPD_RUN_MIN_RESET 6'h3F

// Sleep timing.
`define FSPD_CLK_MHZ        100
`define FSPD_SLEEP_TIME_MS  1000
`define FSPD_SLEEP_CYCLES   (`FSPD_SLEEP_TIME_MS * `FSPD_CLK_MHZ * 1000)

`endif

// ### inc/fspd_pkg.sv
// Types shared by the frame statistics and pixel dump block.
package fspd_pkg;

  // One pixel from the image front end.
  typedef struct packed {
    logic       valid;
    logic       first;
    logic [5:0] value;
  } fspd_pix_t;

  // One register access handed from the serial clock domain.
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } fspd_req_t;

  // Serial port phase, Gray coded along address, write data, read data.
  typedef enum logic [1:0] {
    FSPD_SP_ADDR  = 2'b00,
    FSPD_SP_WDATA = 2'b01,
    FSPD_SP_RDATA = 2'b11
  } fspd_sp_state_t;

endpackage : fspd_pkg

// ### verification/fspd_host_model.sv
// Host controller model that drives the two-wire serial port.
`timescale 1ns/1ns
module fspd_host_model (
  output logic      sck,
  output logic      sdio_d,
  input  wire logic sdio_w
);
  // The serial clock stands high between transfers and runs at 160 ns within them.
  initial begin
    sck = 1'b1;
    sdio_d = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic send8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      sdio_d = b[i];
      #80;
      sck = 1'b1;
      #80;
    end
  endtask : send8

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    #3;
    send8({1'b1, a});
    send8(d);
    #1000;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    #3;
    send8({1'b0, a});
    // A released line shows the inverse so that a stale level cannot pass for read data.
    sdio_d = ~sdio_d;
    // The long hold leaves the core clock ample time to fetch the byte.
    #1000;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      #80;
      sck = 1'b1;
      d[i] = sdio_w;
      #80;
    end
    #1000;
  endtask : rd
endmodule : fspd_host_model

// ### verification/tb.sv
// Self-checking bench for the frame statistics and pixel dump block.
`timescale 1ns/1ns
module tb;
  import fspd_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        sck;
  logic        host_d;
  fspd_pix_t   pix;
  logic        motion;
  logic        force_awake;
  logic        sdio_o;
  logic        sdio_oe;
  logic        awake;
  logic        run;
  logic [7:0]  rbyte;
  logic [5:0]  exp_min;
  logic [14:0] exp_sum;
  int          miscompares;
  int          checked;
  int          sel;
  int          frames;
  wire logic   sdio_w = sdio_oe ? sdio_o : host_d;

  fspd_top #(.SLEEP_CYCLES(20)) i_dut (.clk(clk), .arst_n(arst_n), .sck(sck), .sdio_i(sdio_w), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .pix(pix), .motion(motion), .force_awake(force_awake), .awake(awake));
  fspd_host_model i_host (.sck(sck), .sdio_d(host_d), .sdio_w(sdio_w));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] pval(input int s, input int n);
    case (s)
      0: pval = 6'((n * 7) % 64);
      1: pval = 6'(20 + n % 30);
      default: pval = 6'h3F;
    endcase
  endfunction : pval

  // Frames run back to back, pixel 1 first, with a short gap between them.
  initial begin
    pix = '0;
    frames = 0;
    forever begin
      // A cleared run flag stops the stream between frames.
      wait (run);
      for (int n = 1; n <= 324; n++) begin
        @(posedge clk);
        pix <= '{valid: 1'b1, first: (n == 1), value: pval(sel, n)};
      end
      @(posedge clk);
      pix <= '0;
      repeat (5) @(posedge clk);
      frames++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_frames(input int k);
    int f;
    f = frames;
    wait (frames >= f + k);
  endtask : wait_frames

  task automatic dump_read(output logic [7:0] b);
    for (int t = 0; t < 8; t++) begin
      i_host.rd(7'h48, b);
      if (b[6] === 1'b1) break;
    end
  endtask : dump_read

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    #800000;
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    motion = 1'b0;
    force_awake = 1'b1;
    run = 1'b0;
    sel = 0;
    miscompares = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("awake reset", 8'h01, {7'h00, awake});
    i_host.rd(7'h46, rbyte);
    check("min reset", 8'h00, rbyte);
    i_host.rd(7'h47, rbyte);
    check("total reset", 8'h00, rbyte);
    i_host.rd(7'h50, rbyte);
    check("unmapped", 8'h00, rbyte);
    $display("test reset done");
    run <= 1'b1;
    // Each pattern replaces the last, so stale statistics show up at once.
    for (int s = 0; s < 3; s++) begin
      sel <= s;
      wait_frames(2);
      exp_min = 6'h3F;
      exp_sum = '0;
      for (int n = 1; n <= 324; n++) begin
        exp_sum += pval(s, n);
        if (pval(s, n) < exp_min) exp_min = pval(s, n);
      end
      i_host.rd(7'h46, rbyte);
      check("min", {2'b00, exp_min}, rbyte);
      i_host.rd(7'h47, rbyte);
      check("total", exp_sum[14:7], rbyte);
      if (s == 2) check("total white", 8'h9F, rbyte);
    end
    // The stream pauses so that no frame end can mask a write that lands.
    run <= 1'b0;
    wait_frames(1);
    i_host.wr(7'h46, 8'h15);
    i_host.wr(7'h47, 8'h15);
    i_host.rd(7'h46, rbyte);
    check("min kept", 8'h3F, rbyte);
    i_host.rd(7'h47, rbyte);
    check("total kept", 8'h9F, rbyte);
    run <= 1'b1;
    $display("test stats done");
    sel <= 0;
    wait_frames(2);
    i_host.wr(7'h48, 8'h5A);
    // The pattern changes after capture, so a late read must still return the armed frame.
    wait_frames(2);
    sel <= 1;
    wait_frames(2);
    for (int k = 1; k <= 4; k++) begin
      dump_read(rbyte);
      check("dump pixel", {k == 1, 1'b1, pval(k == 1 ? 0 : 1, k)}, rbyte);
    end
    i_host.wr(7'h48, 8'h00);
    dump_read(rbyte);
    check("dump rewind", {2'b11, pval(1, 1)}, rbyte);
    $display("test dump done");
    @(posedge clk);
    force_awake <= 1'b0;
    repeat (40) @(posedge clk);
    check("asleep", 8'h00, {7'h00, awake});
    motion <= 1'b1;
    @(posedge clk);
    motion <= 1'b0;
    repeat (3) @(posedge clk);
    check("woken", 8'h01, {7'h00, awake});
    force_awake <= 1'b1;
    repeat (40) @(posedge clk);
    check("forced awake", 8'h01, {7'h00, awake});
    $display("test awake done");
    print_verdict();
  end
endmodule : tb
